// File: ppc_defines.vh
// Summary of operation
// (RULE1) Port data reads return pin levels on bits 5..0, zero above.
// (RULE2) Direction bit one tri-states pin; zero drives the output latch.
// (RULE3) Direction bit of pin 3 always reads one; pin is input only.
// (RULE4) Crystal oscillator modes force direction bits 5 and 4 to read one.
// (RULE5) Resistor-capacitor or external clock modes force direction bit 5 to one.
// (RULE6) Analog select bit makes every digital read of that pin zero.
// (RULE7) Analog select never affects output drive of the pin.
// (RULE8) Every pin but pin 3 has its own pull-up enable bit.
// (RULE9) Pull-up forced off whenever the pin is an output.
// (RULE10) Power-on reset disables pull-ups through the global disable bit.
// (RULE11) Pin 3 pull-up follows external reset pin use, no software control.
// (RULE12) Per-pin change interrupt enables, cleared by power-on reset.
// (RULE13) Enabled pins compared with last-read latch; mismatches ORed set flag.
// (RULE14) A set change flag wakes the device from sleep.
// (RULE15) Software accesses port first, then clears the change flag.
// (RULE16) Persisting mismatch keeps setting the flag; clear has no lasting effect.
// (RULE17) Last-read latch survives external-pin and brown-out resets.
// (RULE18) A change coinciding with a port access may be missed.
// (RULE19) Port writes are read-modify-write into the output latch; the code loads pwdata[5:0] straight into it and keeps no pin bits.
// (RULE20) Pin 3 reads zero while it serves as external reset input.
// (RULE21) Change flag lives in interrupt control register, software clearable.
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH
// ****************************************
// Register byte addresses
// ****************************************
`define PPC_A_DATA 12'h000
`define PPC_A_DIR 12'h004
`define PPC_A_ANALOG_SELECT 12'h008
`define PPC_A_PULLUP 12'h00C
`define PPC_A_IOC 12'h010
`define PPC_A_INTCTL 12'h014
`define PPC_A_OPTION 12'h018
`define PPC_A_STATUS 12'h01C
// ****************************************
// Fields and reset values
// ****************************************
`define PPC_DIR_RST 6'h3F
`define PPC_ANALOG_SELECT_RST 8'h0F
`define PPC_PULLUP_RST 6'h37
`define PPC_PULLUP_MASK 6'h37
`define PPC_IOC_RST 6'h00
`define PPC_OPT_GLOBAL_PULLUP_DISABLE 7
`define PPC_OPT_RST 8'h80
`define PPC_INT_FLAG 0
`define PPC_PIN3 3
`define PPC_OSC_LP 3'h0
`define PPC_OSC_XT 3'h1
`define PPC_OSC_HS 3'h2
`define PPC_OSC_EC 3'h3
`endif

// File: ppc_port.v
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "ppc_defines.vh"
module ppc_port (
   input wire pclk,
   input wire presetn,
   input wire por_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [2:0] osc_mode,
   input wire external_reset_pin_enable,
   input wire [5:0] pin_in,
   output reg [5:0] pin_out,
   output reg [5:0] pin_oe,
   output reg [5:0] pin_pullup,
   output reg wake
);
   // ****************************************
   // Pin synchronisers and state
   // ****************************************
   reg [5:0] sync1_q, sync2_q;
   reg [5:0] latch_q, dir_q, pullup_enable_q, change_irq_enable_q, last_read_q;
   reg [7:0] analog_select_q, option_q;
   reg port_change_flag_q;
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire port_acc = acc & (paddr == `PPC_A_DATA);
   wire xtal = (osc_mode == `PPC_OSC_LP) | (osc_mode == `PPC_OSC_XT) | (osc_mode == `PPC_OSC_HS);
   wire [5:0] dir_eff = {1'b1, dir_q[4] | xtal, 1'b1, dir_q[2:0]}; // RULE3 RULE4 RULE5
   wire [5:0] ana = {2'b00, 1'b0, analog_select_q[2:0]} | {2'b00, analog_select_q[3], 3'b000};
   wire [5:0] ana_map = {1'b0, ana[3], 1'b0, ana[2:0]};
   wire [5:0] pin_rd = sync2_q & ~ana_map
                       & ~({5'h00, external_reset_pin_enable} << `PPC_PIN3); // RULE1 RULE6 RULE20
   wire mismatch = |((pin_rd ^ last_read_q) & change_irq_enable_q); // RULE13
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end
   // Power-on only state
   always @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         last_read_q <= 6'h00;
         change_irq_enable_q <= `PPC_IOC_RST; // RULE12
         option_q <= `PPC_OPT_RST; // RULE10
      end else begin
         if (port_acc)
            last_read_q <= pin_rd; // RULE15 RULE17 RULE18
         if (wr && paddr == `PPC_A_IOC)
            change_irq_enable_q <= pwdata[5:0];
         if (wr && paddr == `PPC_A_OPTION)
            option_q <= pwdata[7:0];
      end
   end
   // ****************************************
   // Registers and APB
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 6'h00;
         dir_q <= `PPC_DIR_RST;
         analog_select_q <= `PPC_ANALOG_SELECT_RST;
         pullup_enable_q <= `PPC_PULLUP_RST;
         port_change_flag_q <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~pready;
         pslverr <= 1'b0;
         if (wr) begin
            if (paddr == `PPC_A_DATA)
               latch_q <= (pin_rd & ~6'h3F) | pwdata[5:0]; // RULE19
            else if (paddr == `PPC_A_DIR)
               dir_q <= pwdata[5:0];
            else if (paddr == `PPC_A_ANALOG_SELECT)
               analog_select_q <= pwdata[7:0];
            else if (paddr == `PPC_A_PULLUP)
               pullup_enable_q <= pwdata[5:0] & `PPC_PULLUP_MASK; // RULE8
         end
         // Set beats clear
         if (mismatch)
            port_change_flag_q <= 1'b1; // RULE16
         else if (wr && paddr == `PPC_A_INTCTL)
            port_change_flag_q <= pwdata[`PPC_INT_FLAG]; // RULE21
         if (psel & ~pready & ~pwrite) begin
            if (paddr == `PPC_A_DATA)
               prdata <= {26'h0, pin_rd};
            else if (paddr == `PPC_A_DIR)
               prdata <= {26'h0, dir_eff};
            else if (paddr == `PPC_A_ANALOG_SELECT)
               prdata <= {24'h0, analog_select_q};
            else if (paddr == `PPC_A_PULLUP)
               prdata <= {26'h0, pullup_enable_q};
            else if (paddr == `PPC_A_IOC)
               prdata <= {26'h0, change_irq_enable_q};
            else if (paddr == `PPC_A_INTCTL)
               prdata <= {31'h0, port_change_flag_q};
            else if (paddr == `PPC_A_OPTION)
               prdata <= {24'h0, option_q};
            else if (paddr == `PPC_A_STATUS)
               prdata <= {26'h0, last_read_q};
            else
               prdata <= 32'h00000000;
         end
      end
   end
   // ****************************************
   // Pin drive
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 6'h00;
         pin_oe <= 6'h00;
         pin_pullup <= 6'h00;
         wake <= 1'b0;
      end else begin
         pin_out <= latch_q;
         pin_oe <= ~dir_eff; // RULE2 RULE7
         pin_pullup <= (pullup_enable_q & dir_eff & {6{~option_q[`PPC_OPT_GLOBAL_PULLUP_DISABLE]}} & `PPC_PULLUP_MASK)
                       | ({5'h00, external_reset_pin_enable} << `PPC_PIN3); // RULE9 RULE11
         wake <= port_change_flag_q; // RULE14
      end
   end
endmodule

// File: ppc_pins.sv
`timescale 1ns/10ps
module ppc_pins (
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe,
   input wire [5:0] ext_val,
   output wire [5:0] pin_in
);
   // Driven pins win, board level elsewhere
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// File: ppc_port_props.sv
`timescale 1ns/10ps
module ppc_port_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire [2:0] osc_mode,
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe,
   input wire [5:0] pin_pullup
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_dir = pready && !pwrite && paddr == 12'h004;
   wire wr_dir = pready && pwrite && paddr == 12'h004;
   wire wr_dat = pready && pwrite && paddr == 12'h000;
   wait_state_a: assert property (psel && !penable |=> pready) else $error("late ready");
   pin3_drive_a: assert property (!pin_oe[3]) else $error("pin 3 driven");
   pull_out_a: assert property ((pin_oe & pin_pullup) == 6'h00) else $error("pull-up on output");
   data_high_a: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0)
      else $error("data high bits");
   dir_fixed_a: assert property (rd_dir |-> prdata[31:6] == 26'h0 && prdata[5] && prdata[3])
      else $error("dir fixed bits");
   xtal_dir_a: assert property (rd_dir && osc_mode < 3'h3 |-> prdata[4]) else $error("dir bit 4");
   dir_drive_a: assert property (wr_dir |-> ##2 pin_oe[2:0] == ~$past(pwdata[2:0], 2))
      else $error("drive enable");
   latch_out_a: assert property (wr_dat |-> ##2 pin_out[2:0] == $past(pwdata[2:0], 2))
      else $error("output latch");
   cover property (wr_dir);
   cover property (rd_dir && osc_mode == 3'h1);
   cover property (pin_pullup == 6'h3F);
endmodule
bind ppc_port ppc_port_props u_props (.*);

// File: test_port_pin_control.sv
`timescale 1ns/10ps
module test_port_pin_control;
   reg pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg external_reset_pin_enable = 1'h0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, r;
   reg [2:0] osc_mode = 3'h1;
   reg [5:0] ext_val = 6'h2A;
   wire [31:0] prdata;
   wire pready, pslverr, wake;
   wire [5:0] pin_in, pin_out, pin_oe, pin_pullup;
   integer miscompares = 0, n_compared = 0;
   always #5 pclk = ~pclk;
   ppc_port DUT (.*);
   ppc_pins u_pins (.*);
   task chk(input [31:0] g, input [31:0] e);
      n_compared = n_compared + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'h1 && ++n < 99);
      if (pready !== 1'h1)
         miscompares = miscompares + 1;
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task rd(input [11:0] a, input [31:0] e);
      apb(a, 1'h0, 32'h0);
      chk(r, e);
   endtask
   task settle; repeat (6) @(posedge pclk); endtask
   task t_pull;
      settle;
      chk(pin_pullup, 32'h0);
      apb(12'h018, 1'h1, 32'h0);
      settle;
      chk(pin_pullup, 32'h37);
      external_reset_pin_enable <= 1'h1;
      settle;
      chk(pin_pullup, 32'h3F);
      external_reset_pin_enable <= 1'h0;
      apb(12'h004, 1'h1, 32'h3E);
      settle;
      chk(pin_pullup, 32'h36);
   endtask
   task t_dir;
      apb(12'h004, 1'h1, 32'h0);
      rd(12'h004, 32'h38);
      osc_mode <= 3'h3;
      rd(12'h004, 32'h28);
      chk(pin_oe[2:0], 32'h7);
      rd(12'h020, 32'h0);
   endtask
   task t_io;
      apb(12'h004, 1'h1, 32'h3F);
      apb(12'h008, 1'h1, 32'h0);
      rd(12'h000, 32'h2A);
      apb(12'h008, 1'h1, 32'h0F);
      rd(12'h000, 32'h28);
      external_reset_pin_enable <= 1'h1;
      rd(12'h000, 32'h20);
      external_reset_pin_enable <= 1'h0;
      apb(12'h004, 1'h1, 32'h0);
      apb(12'h000, 1'h1, 32'h01);
      settle;
      chk(pin_oe[0] & pin_out[0], 32'h1);
   endtask
   task t_chg;
      apb(12'h004, 1'h1, 32'h3F);
      rd(12'h000, 32'h28);
      apb(12'h010, 1'h1, 32'h3F);
      ext_val <= 6'h0A;
      settle;
      chk(wake, 32'h1);
      apb(12'h014, 1'h1, 32'h0);
      settle;
      chk(wake, 32'h1);
      rd(12'h000, 32'h08);
      apb(12'h014, 1'h1, 32'h0);
      settle;
      chk(wake, 32'h0);
      ext_val <= 6'h2A;
      presetn <= 1'h0;
      settle;
      presetn <= 1'h1;
      settle;
      chk(wake, 32'h1);
      por_n <= 1'h0;
      presetn <= 1'h0;
      settle;
      por_n <= 1'h1;
      presetn <= 1'h1;
      settle;
      chk(wake, 32'h0);
   endtask
   task conclude;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares = miscompares + 1;
      conclude;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      por_n <= 1'h1;
      t_pull;
      t_dir;
      t_io;
      t_chg;
      conclude;
   end
endmodule
